/* File: motion_table_pkg.sv */
`default_nettype none
package motion_table_pkg;
  localparam int ENTRY_COUNT = 256;
  localparam int INDEX_W = 8;
  localparam int TARGET_W = 16;
  localparam int COUNT_W = 16;
  // Target value meaning "no entry" (blank field)
  localparam logic [15:0] TARGET_BLANK = 16'hFFFF;
  // Externally triggered targets: 10000 + index
  localparam logic [15:0] EXT_BASE = 16'h2710;
  localparam logic [15:0] EXT_LAST = 16'h280F;
  localparam logic [15:0] DIRECT_LIMIT = 16'h0100;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // One wait-time unit is 1 ms
  localparam int WAIT_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAIT_UNIT_CYCLES =
    (WAIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bit positions in the synchronised pin vector
  localparam int PIN_START = 0;
  localparam int PIN_CONT = 1;
  localparam int PIN_JUMP = 2;
  localparam int PIN_TEACH = 5;
  localparam int PIN_SEL = 6;
  localparam int PIN_W = 14;

  typedef struct packed {
    logic [3:0] cmd;
    logic signed [31:0] position;
    logic [15:0] wait_time;
    logic [15:0] next_entry;
    logic [15:0] jump_target_0;
    logic [15:0] jump_target_1;
    logic [15:0] jump_target_2;
    logic [15:0] loop_count;
    logic [15:0] loop_exit;
    logic [15:0] counter_clear;
  } entry_t;

  typedef struct packed {
    logic [7:0] index;
    logic [3:0] cmd;
    logic signed [31:0] position;
  } motion_cmd_t;

  localparam entry_t ENTRY_RESET = '{
    cmd: 4'h0, position: 32'h00000000, wait_time: 16'h0000,
    next_entry: 16'hFFFF, jump_target_0: 16'hFFFF,
    jump_target_1: 16'hFFFF, jump_target_2: 16'hFFFF,
    loop_count: 16'h0000, loop_exit: 16'hFFFF, counter_clear: 16'hFFFF};

  typedef enum {SEQ_IDLE, SEQ_RUN, SEQ_DELAY, SEQ_HOLD} seq_state_t;
endpackage : motion_table_pkg
`default_nettype wire

/* File: motion_table_sequencer.sv */
// Function
// - Table holds 256 entries addressed by the eight-bit entry select.
// - Controller sets entry select then pulses start; execution begins there.
// - Teach turning on writes current position into the selected entry.
// - Taught value is the absolute position count in pulses.
// - Teach changes only the position field of the entry.
// - Table is volatile; nonvolatile copy streams out only on save command.
// - With no jump input seen, continue at the next-entry field.
// - Jump input n seen during an entry selects its jump target n.
// - Several jump inputs: lowest-numbered one wins.
// - Targets in 10XXX form mark the transition as externally triggered.
// - Externally triggered transition waits for the continue input.
// - Nonzero wait time delays the next entry after completion.
// - Below loop count follow next entry; at equality take loop exit.
// - Each entry keeps its own loop counter compared with its loop count.
// - Loop count zero disables looping for that entry.
// - Blank loop exit with count reached ends the sequence.
// - Loop exit in 10XXX form waits for the continue input.
// - On completion, clear the counter named by counter-clear; blank disables.
// - Sequence start resets all loop counters to zero.
// - Without clearing, counters keep counting so loop exit happens once; counters saturate at 65535, so loop count 65535 exits every time once reached.
`timescale 1ns/10ps
`default_nettype none
module motion_table_sequencer #(
  parameter int WAIT_UNIT_CYC = motion_table_pkg::WAIT_UNIT_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Controller pins, asynchronous
  input wire logic [7:0] entry_select_inputs,
  input wire logic sequence_start_input,
  input wire logic continue_input,
  input wire logic jump_input_0,
  input wire logic jump_input_1,
  input wire logic jump_input_2,
  input wire logic teach_input,
  // Motion engine, same clock
  input wire logic signed [31:0] position_count,
  input wire logic motion_done,
  output logic motion_start,
  output motion_table_pkg::motion_cmd_t motion_cmd,
  // Table configuration, same clock
  input wire logic cfg_we,
  input wire logic [7:0] cfg_index,
  input wire motion_table_pkg::entry_t cfg_entry,
  input wire logic [7:0] cfg_rindex,
  output motion_table_pkg::entry_t cfg_rdata,
  // Save to nonvolatile storage
  input wire logic save_request,
  output logic save_busy,
  output logic save_valid,
  output logic [7:0] save_index,
  output motion_table_pkg::entry_t save_data,
  // Status
  output logic running,
  output logic holding,
  output logic seq_end,
  output logic teach_done
);
  localparam int N = motion_table_pkg::ENTRY_COUNT;

  // Pin synchroniser: three stages, change accepted once stages 2 and 3 agree
  logic [13:0] pins;
  logic [13:0] sync1, sync2, sync3, filt, filt_prev;
  logic [13:0] next_filt;
  assign pins = {entry_select_inputs, teach_input, jump_input_2,
                 jump_input_1, jump_input_0, continue_input,
                 sequence_start_input};

  always_comb begin
    next_filt = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
      sync3 <= 14'h0000;
      filt <= 14'h0000;
      filt_prev <= 14'h0000;
    end else if (ce) begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      filt_prev <= filt;
    end
  end

  logic [7:0] sel;
  logic start_rise, cont_rise, teach_rise;
  logic [2:0] jump_now;
  assign sel = filt[motion_table_pkg::PIN_SEL +: 8];
  assign start_rise = filt[motion_table_pkg::PIN_START] &
                      ~filt_prev[motion_table_pkg::PIN_START];
  assign cont_rise = filt[motion_table_pkg::PIN_CONT] &
                     ~filt_prev[motion_table_pkg::PIN_CONT];
  assign teach_rise = filt[motion_table_pkg::PIN_TEACH] &
                      ~filt_prev[motion_table_pkg::PIN_TEACH];
  assign jump_now = filt[motion_table_pkg::PIN_JUMP +: 3];

  // Returns {valid, external, index}
  function automatic logic [9:0] decode(input logic [15:0] t);
    logic [15:0] d;
    d = t - motion_table_pkg::EXT_BASE;
    if (t < motion_table_pkg::DIRECT_LIMIT) begin
      decode = {2'b10, t[7:0]};
    end else if (t >= motion_table_pkg::EXT_BASE &&
                 t <= motion_table_pkg::EXT_LAST) begin
      decode = {2'b11, d[7:0]};
    end else begin
      decode = 10'h000;
    end
  endfunction : decode

  // Sequencer state
  motion_table_pkg::entry_t table_mem [N];
  logic [15:0] loop_cnt [N];
  motion_table_pkg::entry_t next_table [N];
  logic [15:0] next_loop_cnt [N];
  motion_table_pkg::seq_state_t state, next_state;
  logic [7:0] cur, next_cur, pend, next_pend;
  logic pend_ext, next_pend_ext;
  logic [2:0] jump_latch, next_jump_latch;
  logic [15:0] wait_units, next_wait_units;
  logic [31:0] unit_count, next_unit_count;
  logic next_motion_start, next_seq_end, next_teach_done;
  motion_table_pkg::motion_cmd_t next_motion_cmd;
  motion_table_pkg::entry_t next_cfg_rdata;
  // Decision terms, also watched by assertions
  logic [2:0] jl;
  logic [15:0] cnt_new, tgt;
  logic loop_hit;
  logic [9:0] dec, clr_dec;
  logic do_issue;
  logic [7:0] issue_idx;

  always_comb begin
    next_table = table_mem;
    next_loop_cnt = loop_cnt;
    next_state = state;
    next_cur = cur;
    next_pend = pend;
    next_pend_ext = pend_ext;
    next_jump_latch = jump_latch;
    next_wait_units = wait_units;
    next_unit_count = unit_count;
    next_motion_start = 1'b0;
    next_motion_cmd = motion_cmd;
    next_seq_end = 1'b0;
    next_teach_done = 1'b0;
    next_cfg_rdata = table_mem[cfg_rindex];
    do_issue = 1'b0;
    issue_idx = pend;
    jl = jump_latch | jump_now;
    cnt_new = (loop_cnt[cur] == motion_table_pkg::COUNT_MAX) ?
              loop_cnt[cur] : loop_cnt[cur] + 16'h0001;
    loop_hit = (table_mem[cur].loop_count != motion_table_pkg::COUNT_RESET)
               && (cnt_new == table_mem[cur].loop_count);
    if (loop_hit) begin
      tgt = table_mem[cur].loop_exit;
    end else if (jl[0]) begin
      tgt = table_mem[cur].jump_target_0;
    end else if (jl[1]) begin
      tgt = table_mem[cur].jump_target_1;
    end else if (jl[2]) begin
      tgt = table_mem[cur].jump_target_2;
    end else begin
      tgt = table_mem[cur].next_entry;
    end
    dec = decode(tgt);
    clr_dec = decode(table_mem[cur].counter_clear);

    if (cfg_we) begin
      next_table[cfg_index] = cfg_entry;
    end
    // Teach after config so a taught position is not overwritten by a config write in the same cycle
    if (teach_rise) begin
      next_table[sel].position = position_count;
      next_teach_done = 1'b1;
    end

    case (state)
      motion_table_pkg::SEQ_IDLE: begin
        if (start_rise) begin
          for (int i = 0; i < N; i++) begin
            next_loop_cnt[i] = motion_table_pkg::COUNT_RESET;
          end
          do_issue = 1'b1;
          issue_idx = sel;
        end
      end
      motion_table_pkg::SEQ_RUN: begin
        next_jump_latch = jl;
        if (motion_done) begin
          next_loop_cnt[cur] = cnt_new;
          // Clear applies after the increment, so a self-clear wins
          if (clr_dec[9] && !clr_dec[8]) begin
            next_loop_cnt[clr_dec[7:0]] = motion_table_pkg::COUNT_RESET;
          end
          next_pend = dec[7:0];
          next_pend_ext = dec[8];
          if (!dec[9]) begin
            next_state = motion_table_pkg::SEQ_IDLE;
            next_seq_end = 1'b1;
          end else if (table_mem[cur].wait_time != 16'h0000) begin
            next_state = motion_table_pkg::SEQ_DELAY;
            next_wait_units = table_mem[cur].wait_time;
            next_unit_count = 32'h00000000;
          end else if (dec[8]) begin
            next_state = motion_table_pkg::SEQ_HOLD;
          end else begin
            do_issue = 1'b1;
            issue_idx = dec[7:0];
          end
        end
      end
      motion_table_pkg::SEQ_DELAY: begin
        if (unit_count == 32'(WAIT_UNIT_CYC - 1)) begin
          next_unit_count = 32'h00000000;
          next_wait_units = wait_units - 16'h0001;
          if (wait_units == 16'h0001) begin
            if (pend_ext) begin
              next_state = motion_table_pkg::SEQ_HOLD;
            end else begin
              do_issue = 1'b1;
            end
          end
        end else begin
          next_unit_count = unit_count + 32'h00000001;
        end
      end
      motion_table_pkg::SEQ_HOLD: begin
        if (cont_rise) begin
          do_issue = 1'b1;
        end
      end
      default: begin
        next_state = motion_table_pkg::SEQ_IDLE;
      end
    endcase

    if (do_issue) begin
      next_state = motion_table_pkg::SEQ_RUN;
      next_cur = issue_idx;
      next_jump_latch = 3'h0;
      next_motion_start = 1'b1;
      next_motion_cmd = {issue_idx, table_mem[issue_idx].cmd,
                         table_mem[issue_idx].position};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        table_mem[i] <= motion_table_pkg::ENTRY_RESET;
        loop_cnt[i] <= motion_table_pkg::COUNT_RESET;
      end
      state <= motion_table_pkg::SEQ_IDLE;
      cur <= 8'h00;
      pend <= 8'h00;
      pend_ext <= 1'b0;
      jump_latch <= 3'h0;
      wait_units <= 16'h0000;
      unit_count <= 32'h00000000;
      motion_start <= 1'b0;
      motion_cmd <= '0;
      seq_end <= 1'b0;
      teach_done <= 1'b0;
      cfg_rdata <= motion_table_pkg::ENTRY_RESET;
      running <= 1'b0;
      holding <= 1'b0;
    end else if (ce) begin
      table_mem <= next_table;
      loop_cnt <= next_loop_cnt;
      state <= next_state;
      cur <= next_cur;
      pend <= next_pend;
      pend_ext <= next_pend_ext;
      jump_latch <= next_jump_latch;
      wait_units <= next_wait_units;
      unit_count <= next_unit_count;
      motion_start <= next_motion_start;
      motion_cmd <= next_motion_cmd;
      seq_end <= next_seq_end;
      teach_done <= next_teach_done;
      cfg_rdata <= next_cfg_rdata;
      running <= (next_state != motion_table_pkg::SEQ_IDLE);
      holding <= (next_state == motion_table_pkg::SEQ_HOLD);
    end
  end

  // Save stream: one entry per enabled cycle, index 0 upward
  logic [7:0] save_ptr, next_save_ptr;
  logic next_save_busy, next_save_valid;
  logic [7:0] next_save_index;
  motion_table_pkg::entry_t next_save_data;

  always_comb begin
    next_save_ptr = save_ptr;
    next_save_busy = save_busy;
    next_save_valid = 1'b0;
    next_save_index = save_index;
    next_save_data = save_data;
    if (save_busy) begin
      next_save_valid = 1'b1;
      next_save_index = save_ptr;
      next_save_data = table_mem[save_ptr];
      next_save_ptr = save_ptr + 8'h01;
      if (save_ptr == 8'hFF) begin
        next_save_busy = 1'b0;
      end
    end else if (save_request) begin
      next_save_busy = 1'b1;
      next_save_ptr = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      save_ptr <= 8'h00;
      save_busy <= 1'b0;
      save_valid <= 1'b0;
      save_index <= 8'h00;
      save_data <= motion_table_pkg::ENTRY_RESET;
    end else if (ce) begin
      save_ptr <= next_save_ptr;
      save_busy <= next_save_busy;
      save_valid <= next_save_valid;
      save_index <= next_save_index;
      save_data <= next_save_data;
    end
  end

  logic [3:0] sel_cmd;
  logic done_now;
  assign sel_cmd = table_mem[sel].cmd;
  assign done_now = ce && state == motion_table_pkg::SEQ_RUN && motion_done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_issues: assert property (
    (ce && state == motion_table_pkg::SEQ_IDLE && start_rise)
    |=> (motion_start && motion_cmd.index == $past(sel) && running))
    else $error("start did not issue selected entry");
  a_teach_position: assert property (
    (ce && teach_rise)
    |=> (table_mem[$past(sel)].position == $past(position_count)))
    else $error("teach did not store position");
  a_teach_keeps_cmd: assert property (
    (ce && teach_rise && !cfg_we)
    |=> (table_mem[$past(sel)].cmd == $past(sel_cmd)))
    else $error("teach changed command type");
  a_jump_priority: assert property (
    (done_now && !loop_hit && jl[0]) |-> (tgt == table_mem[cur].jump_target_0))
    else $error("jump 0 not preferred");
  a_next_default: assert property (
    (done_now && !loop_hit && jl == 3'h0) |-> (tgt == table_mem[cur].next_entry))
    else $error("next entry not followed");
  a_loop_exit: assert property (
    loop_hit |-> (tgt == table_mem[cur].loop_exit &&
                  table_mem[cur].loop_count != 16'h0000))
    else $error("loop exit misused");
  a_counter_inc: assert property (
    (done_now && !(clr_dec[9] && !clr_dec[8] && clr_dec[7:0] == cur))
    |=> (loop_cnt[$past(cur)] == $past(cnt_new)))
    else $error("loop counter not incremented");
  a_start_clears: assert property (
    (ce && state == motion_table_pkg::SEQ_IDLE && start_rise)
    |=> (loop_cnt[0] == 16'h0000 && loop_cnt[N-1] == 16'h0000))
    else $error("counters not cleared at start");
  a_end_on_blank: assert property (
    (done_now && !dec[9]) |=> (seq_end && !running))
    else $error("sequence did not end");
  a_hold_waits: assert property (
    (ce && holding && !cont_rise) |=> (holding && !motion_start))
    else $error("left hold without continue");
  a_wait_delay: assert property (
    (done_now && dec[9] && table_mem[cur].wait_time != 16'h0000)
    |=> (state == motion_table_pkg::SEQ_DELAY && !motion_start))
    else $error("wait time skipped");
endmodule : motion_table_sequencer
`default_nettype wire

/* File: motion_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none
module motion_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Issue from the sequencer and the chosen answer time
  input wire logic motion_start,
  input wire logic [7:0] done_delay,
  // Completion back to the sequencer
  output logic motion_done
);
  logic busy;
  logic [7:0] left;
  // A new issue restarts the move, as a real engine would
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'h0;
      left <= 8'h00;
      motion_done <= 1'h0;
    end else begin
      motion_done <= 1'h0;
      if (motion_start) begin
        busy <= 1'h1;
        left <= done_delay;
      end else if (busy && left == 8'h00) begin
        busy <= 1'h0;
        motion_done <= 1'h1;
      end else if (busy) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule : motion_engine_model
`default_nettype wire

/* File: motion_table_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module motion_table_sequencer_test;
  localparam logic [15:0] BL = motion_table_pkg::TARGET_BLANK;
  localparam logic [15:0] XB = motion_table_pkg::EXT_BASE;
  logic clk, rst, cfg_we, save_request, save_busy, save_valid;
  logic sequence_start_input, continue_input, teach_input, motion_done;
  logic motion_start, running, holding, seq_end, teach_done;
  logic [7:0] entry_select_inputs, cfg_index, cfg_rindex, save_index;
  logic [7:0] done_delay, ti;
  logic [2:0] jumps, flags;
  logic signed [31:0] position_count;
  motion_table_pkg::motion_cmd_t motion_cmd;
  motion_table_pkg::entry_t cfg_entry, cfg_rdata, save_data, exp_e, got;
  int miscompares, check_count, cycles, issues, saves, k, i0;
  // Bit n of pins is jump input n
  typedef struct packed {logic [2:0] pins; logic [7:0] dest;} row_t;
  row_t rows[6] = '{'{3'h0, 8'h01}, '{3'h1, 8'h02}, '{3'h2, 8'h03},
    '{3'h4, 8'h04}, '{3'h6, 8'h03}, '{3'h7, 8'h02}};
  logic [7:0] seq_c[10] = '{0, 1, 0, 1, 2, 0, 1, 0, 1, 2};
  logic [7:0] seq_n[10] = '{0, 1, 0, 1, 2, 0, 1, 0, 1, 0};
  assign flags = {holding, teach_done, seq_end};

  motion_table_sequencer #(.WAIT_UNIT_CYC(4)) i_motion_table_sequencer (
    .clk(clk), .rst(rst), .ce(1'h1),
    .entry_select_inputs(entry_select_inputs),
    .sequence_start_input(sequence_start_input),
    .continue_input(continue_input), .jump_input_0(jumps[0]),
    .jump_input_1(jumps[1]), .jump_input_2(jumps[2]),
    .teach_input(teach_input), .position_count(position_count),
    .motion_done(motion_done), .motion_start(motion_start),
    .motion_cmd(motion_cmd), .cfg_we(cfg_we), .cfg_index(cfg_index),
    .cfg_entry(cfg_entry), .cfg_rindex(cfg_rindex), .cfg_rdata(cfg_rdata),
    .save_request(save_request), .save_busy(save_busy),
    .save_valid(save_valid), .save_index(save_index),
    .save_data(save_data), .running(running), .holding(holding),
    .seq_end(seq_end), .teach_done(teach_done));
  motion_engine_model i_motion_engine_model (.clk(clk), .rst(rst),
    .motion_start(motion_start), .done_delay(done_delay),
    .motion_done(motion_done));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (motion_start === 1'h1) issues++;
    if (save_valid === 1'h1) saves++;
    // Ceiling of 40000 cycles is dozens of times the expected run length
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic motion_table_pkg::entry_t mk(input logic [15:0] nx,
      j0, j1, j2, lc, lx, cc, wt);
    return '{4'h3, 32'h00001F40, wt, nx, j0, j1, j2, lc, lx, cc};
  endfunction : mk

  task automatic put(input logic [7:0] i, input motion_table_pkg::entry_t e);
    cfg_index = i;
    cfg_entry = e;
    cfg_we = 1'h1;
    tick(1);
    cfg_we = 1'h0;
    tick(1);
  endtask : put

  task automatic next_issue(input logic [7:0] want, input string msg);
    int n;
    for (n = 0; n < 400 && motion_start !== 1'h1; n++) tick(1);
    chk(motion_start === 1'h1 && motion_cmd.index === want, msg);
    tick(1);
  endtask : next_issue

  // Flag 0 end, 1 teach done, 2 holding; k returns the cycles waited
  task automatic await(input int w, output int n);
    for (n = 0; n < 400 && flags[w] !== 1'h1; n++) tick(1);
  endtask : await

  task automatic start_at(input logic [7:0] i);
    entry_select_inputs = i;
    tick(4);
    sequence_start_input = 1'h1;
    next_issue(i, "first entry");
    sequence_start_input = 1'h0;
    chk(motion_cmd.cmd === 4'h3 && motion_cmd.position === 32'h00001F40,
      "issued command");
  endtask : start_at

  task automatic do_reset;
    rst = 1'h1;
    tick(4);
    rst = 1'h0;
    tick(4);
  endtask : do_reset

  task automatic ext_case(input logic [7:0] s, t, input int min_wait);
    start_at(s);
    for (k = 0; k < 100 && motion_done !== 1'h1; k++) tick(1);
    i0 = issues;
    await(2, k);
    chk(k >= min_wait && k < 400 && issues == i0, "hold entry");
    tick(10);
    chk(holding === 1'h1 && issues == i0, "hold kept");
    continue_input = 1'h1;
    next_issue(t, "after continue");
    continue_input = 1'h0;
    await(0, k);
    tick(1);
  endtask : ext_case

  initial begin
    {rst, cfg_we, save_request, sequence_start_input} = 4'h8;
    {continue_input, teach_input, jumps} = 5'h00;
    {entry_select_inputs, cfg_index, cfg_rindex} = 24'h000000;
    {position_count, cfg_entry} = '0;
    {miscompares, check_count, cycles, issues, saves} = '0;
    done_delay = 8'h06;
    do_reset();
    chk(running === 1'h0 && cfg_rdata === motion_table_pkg::ENTRY_RESET,
      "reset state");
    $display("test reset done");
    put(8'h00, mk(16'h0001, 16'h0002, 16'h0003, 16'h0004, 0, BL, BL, 0));
    foreach (rows[r]) begin
      jumps = rows[r].pins;
      start_at(8'h00);
      next_issue(rows[r].dest, "jump choice");
      await(0, k);
      chk(k < 400 && running === 1'h0, "sequence end");
      tick(1);
      jumps = 3'h0;
    end
    $display("test jumps done");
    for (int c = 1; c >= 0; c--) begin
      do_reset();
      put(8'h00, mk(16'h0001, BL, BL, BL, 0, BL, BL, 0));
      put(8'h01, mk(16'h0000, BL, BL, BL, 16'h0002, 16'h0002, BL, 0));
      put(8'h02, mk(16'h0000, BL, BL, BL, 0, BL, c ? 16'h0001 : BL, 0));
      start_at(8'h00);
      for (int n = 1; n < 10; n++) begin
        next_issue(c ? seq_c[n] : seq_n[n], "loop order");
      end
    end
    $display("test loops done");
    do_reset();
    put(8'h05, mk(16'h0005, BL, BL, BL, 16'h0003, BL, BL, 0));
    repeat (2) begin
      i0 = issues;
      start_at(8'h05);
      await(0, k);
      chk(k < 400 && issues - i0 == 3, "loop exit end");
      tick(1);
    end
    done_delay = 8'h14;
    put(8'h06, mk(XB + 16'h0007, BL, BL, BL, 0, BL, BL, 16'h0002));
    put(8'h08, mk(16'h0008, BL, BL, BL, 16'h0001, XB + 16'h0009, BL, 0));
    ext_case(8'h06, 8'h07, 8);
    ext_case(8'h08, 8'h09, 0);
    $display("test external done");
    for (int i = 0; i < 2; i++) begin
      ti = i ? 8'hFF : 8'h0C;
      put(ti, mk(16'h0001, 16'h0002, BL, BL, 16'h0004, 16'h0005, BL, 0));
      position_count = i ? 32'h00009678 : 32'hFFFFCE00;
      entry_select_inputs = ti;
      tick(4);
      teach_input = 1'h1;
      await(1, k);
      teach_input = 1'h0;
      exp_e = mk(16'h0001, 16'h0002, BL, BL, 16'h0004, 16'h0005, BL, 0);
      exp_e.position = position_count;
      cfg_rindex = ti;
      tick(2);
      chk(k < 400 && cfg_rdata === exp_e, "teach result");
    end
    chk(saves == 0, "no save without request");
    save_request = 1'h1;
    tick(1);
    save_request = 1'h0;
    for (k = 0; k < 300; k++) begin
      if (save_valid === 1'h1 && save_index === 8'hFF) got = save_data;
      tick(1);
    end
    chk(saves == 256 && got === exp_e, "save stream");
    chk(save_busy === 1'h0 && save_valid === 1'h0, "save finished");
    $display("test teach and save done");
    give_verdict();
  end
endmodule : motion_table_sequencer_test
`default_nettype wire
